//--- rtl/oms_pkg.sv
// package for the operating state and buffer gate status block
// assumes a single 100 MHz clock and a byte wide register read port
package oms_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OMS_STATUS_OFFSET  = 8'h14;
   localparam int         OMS_GATE_ERR_BIT   = 7;
   localparam int         OMS_GATE_CNT_LSB   = 2;
   localparam int         OMS_GATE_CNT_W     = 5;
   localparam int         OMS_STATE_LSB      = 0;
   localparam logic       OMS_GATE_ERR_RESET = 1'b0;
   localparam logic [4:0] OMS_GATE_CNT_RESET = 5'h00;
   localparam logic [1:0] OMS_BUF_MODE_OFF   = 2'h0;
   localparam int         OMS_BUF_CNT_W      = 6;

   // ---------------------------------------------------------------
   // operating states, encoded as the status field shows them
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OMS_STANDBY  = 2'h0,
      OMS_WAKE     = 2'h1,
      OMS_SLEEP    = 2'h2,
      OMS_EXTERNAL_TRIGGER_STATE = 2'h3
   } oms_state_type;

endpackage

//--- rtl/oms_gate_err.sv
// buffer gate error flag and overrun period counter
// assumes strobes are one-cycle pulses synchronous to sys_clk_i
module oms_gate_err
   import oms_pkg::*;
#(
   parameter int CNT_W = OMS_GATE_CNT_W
) (
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   // events
   input  wire logic             gate_en_i,
   input  wire logic             sample_stb_i,
   input  wire logic             buf_not_empty_i,
   input  wire logic             clear_i,
   // status
   output logic                  err_o,
   output logic [CNT_W-1:0]      cnt_o
);

   logic             err_r;
   logic             err_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // a new overrun in the clear cycle wins: the set outranks the clear
   always_comb begin
      err_nxt = err_r;
      cnt_nxt = cnt_r;
      if (clear_i) begin
         err_nxt = 1'b0;
         cnt_nxt = '0;
      end
      if (sample_stb_i) begin
         if (gate_en_i && buf_not_empty_i) begin
            err_nxt = 1'b1;
         end
         // counter saturates rather than wrapping to a misleading 0
         if (err_r && !clear_i && (cnt_r != '1)) begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   // no other path drops the flag while data remains
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         err_r <= OMS_GATE_ERR_RESET;
         cnt_r <= CNT_W'(OMS_GATE_CNT_RESET);
      end else begin
         err_r <= err_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign err_o = err_r;
   assign cnt_o = cnt_r;

endmodule

//--- rtl/oms_status.sv
// operating state and buffer gate status register
// assumes the serial front end presents a byte read/write port, the
// sequencer supplies state requests, all inputs synchronous to sys_clk_i
module oms_status
   import oms_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   // register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_rd_i,
   input  wire logic       reg_wr_i,
   output logic [7:0]      reg_rdata_o,
   // configuration from other registers
   input  wire logic       boot_strap_pin_i,
   input  wire logic       motion_detect_setting_i,
   input  wire logic       active_i,
   input  wire logic       soft_reset_i,
   input  wire logic       go_sleep_i,
   input  wire logic       go_wake_i,
   input  wire logic       second_pin_function_select_i,
   input  wire logic       ext_trigger_i,
   input  wire logic       meas_done_i,
   input  wire logic       wake_out_en_i,
   input  wire logic       wake_output_pin_choice_i,
   input  wire logic       interrupt_pin_polarity_i,
   // buffer events
   input  wire logic       gate_en_i,
   input  wire logic       sample_stb_i,
   input  wire logic [5:0] buf_cnt_i,
   input  wire logic       buf_flush_i,
   input  wire logic       buf_mode_wr_i,
   input  wire logic [1:0] buf_mode_i,
   // buffer and detector control
   output logic            buf_discard_o,
   output logic            debounce_rst_o,
   // interrupt pins, enable low while driven
   output logic            interrupt_pin_one_o,
   output logic            interrupt_pin_one_oe_n_o,
   output logic            interrupt_pin_two_o,
   output logic            interrupt_pin_two_oe_n_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   oms_state_type state_r;
   oms_state_type state_nxt;
   logic          boot_r;
   logic          boot_nxt;
   logic [7:0]    rdata_r;
   logic [7:0]    rdata_nxt;
   logic          discard_r;
   logic          discard_nxt;
   logic          deb_r;
   logic          deb_nxt;
   logic          p1_r;
   logic          p1_nxt;
   logic          p1_oe_n_r;
   logic          p1_oe_n_nxt;
   logic          p2_r;
   logic          p2_nxt;
   logic          p2_oe_n_r;
   logic          p2_oe_n_nxt;
   logic          to_active;
   logic          buf_off;
   logic          gate_clr;
   logic          gate_err;
   logic [OMS_GATE_CNT_W-1:0] gate_cnt;

   // true in wake, sleep or trigger, false only in standby
   function automatic logic is_run(oms_state_type s);
      return s != OMS_STANDBY;
   endfunction

   // ---------------------------------------------------------------
   // operating state sequencer
   // ---------------------------------------------------------------
   // the strap is caught on the first clocked cycle after reset
   always_comb begin
      state_nxt = state_r;
      boot_nxt  = 1'b0;
      if (boot_r || soft_reset_i) begin
         if (boot_strap_pin_i && motion_detect_setting_i) begin
            state_nxt = OMS_WAKE;
         end else begin
            state_nxt = OMS_STANDBY;
         end
      end else begin
         case (state_r)
            OMS_STANDBY: begin
               if (active_i) begin
                  if (second_pin_function_select_i
                      && !boot_strap_pin_i) begin
                     state_nxt = OMS_EXTERNAL_TRIGGER_STATE;
                  end else begin
                     state_nxt = OMS_WAKE;
                  end
               end
            end
            OMS_WAKE: begin
               if (!active_i) begin
                  state_nxt = OMS_STANDBY;
               end else if (second_pin_function_select_i
                            && !boot_strap_pin_i) begin
                  if (meas_done_i) begin
                     state_nxt = OMS_EXTERNAL_TRIGGER_STATE;
                  end
               end else if (go_sleep_i) begin
                  state_nxt = OMS_SLEEP;
               end
            end
            OMS_SLEEP: begin
               if (!active_i) begin
                  state_nxt = OMS_STANDBY;
               end else if (go_wake_i) begin
                  state_nxt = OMS_WAKE;
               end
            end
            OMS_EXTERNAL_TRIGGER_STATE: begin
               if (!active_i || boot_strap_pin_i) begin
                  state_nxt = OMS_STANDBY;
               end else if (ext_trigger_i) begin
                  state_nxt = OMS_WAKE;
               end
            end
            default: state_nxt = OMS_STANDBY;
         endcase
      end
   end

   assign to_active = (state_r == OMS_STANDBY) && is_run(state_nxt);
   assign buf_off   = buf_mode_wr_i && (buf_mode_i == OMS_BUF_MODE_OFF);
   assign gate_clr  = (buf_cnt_i == '0) || buf_flush_i || buf_off
                      || to_active;

   // ---------------------------------------------------------------
   // gate error tracker
   // ---------------------------------------------------------------
   oms_gate_err #(
      .CNT_W           (OMS_GATE_CNT_W)
   ) u_gate (
      .sys_clk_i       (sys_clk_i),
      .rst_n_i         (rst_n_i),
      .gate_en_i       (gate_en_i),
      .sample_stb_i    (sample_stb_i),
      .buf_not_empty_i (buf_cnt_i != '0),
      .clear_i         (gate_clr),
      .err_o           (gate_err),
      .cnt_o           (gate_cnt)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb begin
      rdata_nxt = rdata_r;
      // writes never reach the status fields; only reads load data
      if (reg_rd_i && !reg_wr_i) begin
         if (reg_addr_i == OMS_STATUS_OFFSET) begin
            rdata_nxt = {gate_err, gate_cnt, state_r};
         end else begin
            rdata_nxt = 8'h00;
         end
      end
      discard_nxt = buf_off || to_active;
      deb_nxt = is_run(state_nxt)
                && (state_nxt != state_r);
      p1_nxt      = 1'b0;
      p1_oe_n_nxt = 1'b1;
      p2_nxt      = 1'b0;
      p2_oe_n_nxt = 1'b1;
      if (wake_out_en_i && (state_nxt == OMS_WAKE)) begin
         if (wake_output_pin_choice_i) begin
            p2_nxt      = interrupt_pin_polarity_i;
            p2_oe_n_nxt = 1'b0;
         end else begin
            p1_nxt      = interrupt_pin_polarity_i;
            p1_oe_n_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_r   <= OMS_STANDBY;
         boot_r    <= 1'b1;
         rdata_r   <= 8'h00;
         discard_r <= 1'b0;
         deb_r     <= 1'b0;
         p1_r      <= 1'b0;
         p1_oe_n_r <= 1'b1;
         p2_r      <= 1'b0;
         p2_oe_n_r <= 1'b1;
      end else begin
         state_r   <= state_nxt;
         boot_r    <= boot_nxt;
         rdata_r   <= rdata_nxt;
         discard_r <= discard_nxt;
         deb_r     <= deb_nxt;
         p1_r      <= p1_nxt;
         p1_oe_n_r <= p1_oe_n_nxt;
         p2_r      <= p2_nxt;
         p2_oe_n_r <= p2_oe_n_nxt;
      end
   end

   assign reg_rdata_o              = rdata_r;
   assign buf_discard_o            = discard_r;
   assign debounce_rst_o           = deb_r;
   assign interrupt_pin_one_o      = p1_r;
   assign interrupt_pin_one_oe_n_o = p1_oe_n_r;
   assign interrupt_pin_two_o      = p2_r;
   assign interrupt_pin_two_oe_n_o = p2_oe_n_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_overrun;
      sample_stb_i && gate_en_i && (buf_cnt_i != '0);
   endsequence

   // end of a triggered measurement that must fall back to waiting
   sequence s_measure_end;
      state_r == OMS_WAKE && active_i && second_pin_function_select_i
      && !boot_strap_pin_i && meas_done_i && !soft_reset_i && !boot_r;
   endsequence

   gate_err_set_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_overrun |=> gate_err)
      else $error("gate error not set on overrun");
   gate_err_clr_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (gate_clr && !(sample_stb_i && gate_en_i && (buf_cnt_i != '0)))
      |=> !gate_err && gate_cnt == '0)
      else $error("gate error or count not cleared");
   gate_err_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (gate_err && !gate_clr) |=> gate_err)
      else $error("gate error dropped without clear");
   gate_cnt_step_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (gate_err && !gate_clr && sample_stb_i && gate_cnt != 5'h1f)
      |=> gate_cnt == $past(gate_cnt) + 5'h01)
      else $error("overrun count did not advance");
   status_read_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (reg_rd_i && !reg_wr_i && reg_addr_i == OMS_STATUS_OFFSET)
      |=> reg_rdata_o[1:0] == $past(state_r))
      else $error("status read shows wrong state");
   write_ignored_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (reg_wr_i && !reg_rd_i) |=> $stable(reg_rdata_o))
      else $error("write changed the read data");
   buf_discard_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (buf_mode_wr_i && buf_mode_i == OMS_BUF_MODE_OFF) |=> buf_discard_o)
      else $error("buffer not discarded on disable");
   boot_state_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      ((boot_r || soft_reset_i) && !boot_strap_pin_i)
      |=> state_r == OMS_STANDBY)
      else $error("boot did not enter standby");
   boot_wake_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      ((boot_r || soft_reset_i) && boot_strap_pin_i
       && motion_detect_setting_i) |=> state_r == OMS_WAKE)
      else $error("boot did not enter wake");
   no_trig_strap_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (boot_strap_pin_i && state_r != OMS_EXTERNAL_TRIGGER_STATE)
      |=> state_r != OMS_EXTERNAL_TRIGGER_STATE)
      else $error("trigger state entered with strap high");
   trig_measure_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == OMS_EXTERNAL_TRIGGER_STATE && ext_trigger_i && active_i
       && !boot_strap_pin_i && !soft_reset_i && !boot_r)
      |=> state_r == OMS_WAKE)
      else $error("trigger did not start measurement");
   trig_return_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_measure_end |=> state_r == OMS_EXTERNAL_TRIGGER_STATE)
      else $error("measurement did not return to trigger wait");
   debounce_rst_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r != $past(state_r) && state_r != OMS_STANDBY)
      |-> debounce_rst_o)
      else $error("debounce reset missing on state entry");
   wake_pin_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == OMS_WAKE && $past(wake_out_en_i)
       && !$past(wake_output_pin_choice_i))
      |-> !interrupt_pin_one_oe_n_o
          && interrupt_pin_one_o == $past(interrupt_pin_polarity_i))
      else $error("wake level not driven on pin one");
   wake_pin_two_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == OMS_WAKE && $past(wake_out_en_i)
       && $past(wake_output_pin_choice_i))
      |-> !interrupt_pin_two_oe_n_o
          && interrupt_pin_two_o == $past(interrupt_pin_polarity_i))
      else $error("wake level not driven on pin two");
   pins_idle_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r != OMS_WAKE)
      |-> interrupt_pin_one_oe_n_o && interrupt_pin_two_oe_n_o)
      else $error("interrupt pin driven outside wake");

endmodule

//--- dv/oms_host_model.sv
// host side of the status block: issues single byte reads and writes
// assumes one request pulse at a time, spaced by the bench
module oms_host_model (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   // bench side
   input  wire logic       req_i,
   input  wire logic       wreq_i,
   input  wire logic [7:0] addr_i,
   output logic            valid_o,
   output logic [7:0]      data_o,
   // register port
   output logic [7:0]      reg_addr_o,
   output logic            reg_rd_o,
   output logic            reg_wr_o,
   input  wire logic [7:0] reg_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // data is taken one cycle after the read strobe
   assign data_o = reg_rdata_i;
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rd_o   <= 1'b0;
         reg_wr_o   <= 1'b0;
         valid_o    <= 1'b0;
         reg_addr_o <= 8'h00;
      end else begin
         reg_rd_o <= req_i;
         reg_wr_o <= wreq_i;
         valid_o  <= reg_rd_o;
         if (req_i | wreq_i) begin
            reg_addr_o <= addr_i;
         end
      end
   end
endmodule

//--- dv/testbench.sv
// self-checking bench for the status register block
// assumes the bench spaces reads so one result is pending at most
module testbench
   import oms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst_n = 0, hreq = 0, wreq = 0, strap = 0, mot = 0;
   logic act = 0, srst = 0, slp = 0, wk = 0, sel = 0, trg = 0, mdone = 0;
   logic woe = 0, wpin = 0, pol = 0, gen = 0, stb = 0, fl = 0, mwr = 0;
   logic [1:0]  mode = 2'h1;
   logic [5:0]  bcnt = 6'h00;
   logic [7:0]  haddr = 8'h00, addr, rdata, hdata;
   logic        rd, wr, hval, disc, dbc, p1, p1n, p2, p2n;
   logic        seen_disc = 0, seen_dbc = 0;
   logic [31:0] seed = 32'h91ba;
   logic [7:0]  expq[$];
   int          mismatches = 0, n_tests = 0, cyc = 0, n;

   initial forever #5 sys_clk = ~sys_clk;

   oms_host_model host_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .req_i(hreq), .wreq_i(wreq), .addr_i(haddr), .valid_o(hval),
      .data_o(hdata), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
      .reg_rdata_i(rdata));

   oms_status dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_rdata_o(rdata),
      .boot_strap_pin_i(strap), .motion_detect_setting_i(mot),
      .active_i(act), .soft_reset_i(srst), .go_sleep_i(slp),
      .go_wake_i(wk), .second_pin_function_select_i(sel),
      .ext_trigger_i(trg), .meas_done_i(mdone), .wake_out_en_i(woe),
      .wake_output_pin_choice_i(wpin), .interrupt_pin_polarity_i(pol),
      .gate_en_i(gen), .sample_stb_i(stb), .buf_cnt_i(bcnt),
      .buf_flush_i(fl), .buf_mode_wr_i(mwr), .buf_mode_i(mode),
      .buf_discard_o(disc), .debounce_rst_o(dbc),
      .interrupt_pin_one_o(p1), .interrupt_pin_one_oe_n_o(p1n),
      .interrupt_pin_two_o(p2), .interrupt_pin_two_oe_n_o(p2n));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s exp %b got %b", nm, e, s);
      end
   endtask
   // the note goes on the queue before the request leaves
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      haddr <= a;
      hreq  <= 1'b1;
      tick(1);
      hreq <= 1'b0;
      tick(4);
   endtask
   task automatic samples(input int k);
      for (int i = 0; i < k; i++) begin
         stb <= 1'b1;
         tick(1);
         stb <= 1'b0;
         tick(1);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // result watcher and hang guard
   // ---------------------------------------------------------------
   always @(posedge sys_clk) begin
      cyc++;
      if (hval) chk8("status", expq.pop_front(), hdata);
      if (disc) seen_disc <= 1'b1;
      if (dbc) seen_dbc <= 1'b1;
      if (cyc > 8000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // stimulus
   // ---------------------------------------------------------------
   initial begin
      tick(16);
      rst_n <= 1'b1;
      tick(3);
      rd_exp(OMS_STATUS_OFFSET, 8'h00);
      rd_exp(8'h15, 8'h00);
      bcnt <= 6'h05;
      samples(2);
      rd_exp(OMS_STATUS_OFFSET, 8'h00);
      gen <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         n = int'(seed[2:0]) + 1;
         bcnt <= seed[13:8] | 6'h01;
         samples(n);
         wreq <= 1'b1;
         tick(1);
         wreq <= 1'b0;
         tick(2);
         rd_exp(OMS_STATUS_OFFSET, {1'b1, 5'(n - 1), 2'h0});
         if (k == 0) bcnt <= 6'h00;
         if (k == 1) fl <= 1'b1;
         if (k == 2) mwr <= 1'b1;
         mode <= OMS_BUF_MODE_OFF;
         tick(1);
         fl  <= 1'b0;
         mwr <= 1'b0;
         tick(3);
         rd_exp(OMS_STATUS_OFFSET, 8'h00);
      end
      chk1("discard", 1'b1, seen_disc);
      bcnt <= 6'h02;
      samples(2);
      rd_exp(OMS_STATUS_OFFSET, 8'h84);
      act <= 1'b1;
      tick(4);
      rd_exp(OMS_STATUS_OFFSET, 8'h01);
      chk1("debounce", 1'b1, seen_dbc);
      woe <= 1'b1;
      pol <= 1'b1;
      tick(3);
      chk1("pin1 oe_n", 1'b0, p1n);
      chk1("pin1", 1'b1, p1);
      wpin <= 1'b1;
      pol  <= 1'b0;
      tick(3);
      chk1("pin2 oe_n", 1'b0, p2n);
      chk1("pin2", 1'b0, p2);
      chk1("pin1 released", 1'b1, p1n);
      slp <= 1'b1;
      tick(1);
      slp <= 1'b0;
      tick(3);
      rd_exp(OMS_STATUS_OFFSET, 8'h02);
      wk <= 1'b1;
      tick(1);
      wk <= 1'b0;
      tick(3);
      rd_exp(OMS_STATUS_OFFSET, 8'h01);
      act <= 1'b0;
      tick(4);
      rd_exp(OMS_STATUS_OFFSET, 8'h00);
      sel <= 1'b1;
      act <= 1'b1;
      tick(4);
      rd_exp(OMS_STATUS_OFFSET, 8'h03);
      trg <= 1'b1;
      tick(1);
      trg <= 1'b0;
      tick(2);
      rd_exp(OMS_STATUS_OFFSET, 8'h01);
      mdone <= 1'b1;
      tick(1);
      mdone <= 1'b0;
      tick(2);
      rd_exp(OMS_STATUS_OFFSET, 8'h03);
      // drop the run request too, or standby would go straight to wake
      strap <= 1'b1;
      act   <= 1'b0;
      tick(3);
      rd_exp(OMS_STATUS_OFFSET, 8'h00);
      sel  <= 1'b0;
      mot  <= 1'b1;
      srst <= 1'b1;
      act  <= 1'b1;
      tick(1);
      srst <= 1'b0;
      tick(4);
      rd_exp(OMS_STATUS_OFFSET, 8'h01);
      tick(4);
      chk1("queue empty", 1'b1, expq.size() == 0);
      wrap_up();
   end
endmodule
